/* timer_sel_pkg.sv */
// constants and carrier types for the timer clock and clear select block
// assumes one peripheral clock domain and a plain register port
package timer_sel_pkg;

  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int REG_W = 8;
  localparam int ADDR_W = 4;
  localparam int PRE_W = 12;
  localparam int NUM_PINS = 4;
  localparam int CLK_PERIOD_NS = 10;

  // register offsets; control register of channel n sits at OFS_CTRL_BASE + n
  localparam logic [ADDR_W-1:0] OFS_CTRL_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SYNC = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_BUFFER = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_START = 4'h9;

  // control register fields
  localparam int CLR_MSB = 7;
  localparam int CLR_LSB = 5;
  localparam int EDGE_MSB = 4;
  localparam int EDGE_LSB = 3;
  localparam int CLK_MSB = 2;
  localparam int CLK_LSB = 0;

  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [REG_W-1:0] CTRL_MASK_NARROW = 8'h7F;
  localparam logic [NUM_CH-1:0] SYNC_RESET = 6'h00;
  localparam logic [NUM_CH-1:0] PHASE_RESET = 6'h00;
  localparam logic [NUM_CH-1:0] PHASE_CAPABLE = 6'h36;
  localparam logic [3:0] BUFFER_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] START_RESET = 6'h00;

  // buffer register bits: C and D of channel 0, then of channel 3
  localparam int BUF_C_CH0 = 0;
  localparam int BUF_D_CH0 = 1;
  localparam int BUF_C_CH3 = 2;
  localparam int BUF_D_CH3 = 3;

  // clear select codes
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LOW = 2'h3;

  // prescaler exponents: divide ratio is two to this power
  localparam logic [3:0] EXP_DIV1 = 4'h0;
  localparam logic [3:0] EXP_DIV4 = 4'h2;
  localparam logic [3:0] EXP_DIV16 = 4'h4;
  localparam logic [3:0] EXP_DIV64 = 4'h6;
  localparam logic [3:0] EXP_DIV256 = 4'h8;
  localparam logic [3:0] EXP_DIV1024 = 4'hA;
  localparam logic [3:0] EXP_DIV4096 = 4'hC;

  localparam logic [1:0] PIN_A = 2'h0;
  localparam logic [1:0] PIN_B = 2'h1;
  localparam logic [1:0] PIN_C = 2'h2;
  localparam logic [1:0] PIN_D = 2'h3;

  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_CASCADE} src_kind_type;

  typedef struct packed {
    src_kind_type kind;
    logic [3:0] exp;
    logic [1:0] pin;
  } clk_src_type;

  // compare match or input capture pulses, one bit per channel
  typedef struct packed {
    logic [NUM_CH-1:0] a;
    logic [NUM_CH-1:0] b;
    logic [NUM_CH-1:0] c;
    logic [NUM_CH-1:0] d;
  } tgr_event_type;

  // count pulses and direction from the phase counting logic
  typedef struct packed {
    logic [NUM_CH-1:0] step;
    logic [NUM_CH-1:0] down;
  } phase_type;

endpackage : timer_sel_pkg

/* timer_count_clock_clear_select.sv */
// six channel counters with per-channel clock, edge and clear selection
// assumes compare/capture and phase logic on the same clock drive the event inputs,
// and software changes a channel's selection only while it is stopped
//
// Overview of operation
// - ch0/3: 000,100 off; 001 A; 010 B
// - ch0/3: 101 clears on C, 110 on D
// - 011/111 clear with synchronous partner clears
// - sync clear needs own sync bit set
// - buffered C or D never clears
// - ch1/2/4/5 clear msb reads zero
// - ch1/2/4/5: 00 off, 01 A, 10 B, 11 sync
// - internal: 00 falling, 01 rising edge
// - external: 00 rising, 01 falling edge
// - edge msb set counts both edges
// - ch0: /1, /4, pins A to D
// - ch1: /1,/4,/16,/64,/256, pins A, B
// - ch1 code 111 counts channel 2 carries
// - phase mode ignores clock select
// - ch2: /1, /4, pins A, B, C
// - ch3: /1,/4,/64,/1024,/4096, pin A
// - ch4: pins A, C; 111 counts ch5 carries
// - ch5: /1, pins A, C, D
// - edge ignored for /1 and cascade
// - phase mode ignores edge selection
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps

module timer_count_clock_clear_select
  import timer_sel_pkg::*;
#(
  // exponent nibble per code (code 7 highest) per channel, used only for unlisted codes
  parameter logic [NUM_CH-1:0][7:0][3:0] UNLISTED_DIV_EXP = {NUM_CH{32'hA864_6420}}
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [REG_W-1:0] reg_rdata_o,
  input wire tgr_event_type tgr_event_i,
  input wire phase_type phase_i,
  input wire logic [NUM_PINS-1:0] ext_clock_pin_i,
  output logic [NUM_CH-1:0][CNT_W-1:0] channel_counter_o,
  output logic [NUM_CH-1:0] counter_clear_o,
  output logic [NUM_CH-1:0] carry_o
);

  logic [NUM_CH-1:0][REG_W-1:0] timer_control;
  logic [NUM_CH-1:0] sync_operation_register;
  logic [NUM_CH-1:0] phase_enable;
  logic [3:0] buffer_select;
  logic [NUM_CH-1:0] counter_start;
  logic [PRE_W-1:0] prescaler;
  logic [PRE_W-1:0] prescaler_prev;
  logic [PRE_W-1:0] pre_rise;
  logic [PRE_W-1:0] pre_fall;
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic [NUM_CH-1:0] count_tick;
  logic [NUM_CH-1:0] count_down;
  logic [NUM_CH-1:0] own_clear;
  logic [NUM_CH-1:0] next_clear;

  function automatic logic is_narrow(input int ch);
    return (ch != 0) && (ch != 3);
  endfunction : is_narrow

  function automatic logic ctrl_hit(input logic [ADDR_W-1:0] addr);
    return (addr >= OFS_CTRL_BASE) && (addr < OFS_SYNC);
  endfunction : ctrl_hit

  // maps a clock select code to its source for one channel
  function automatic clk_src_type decode_clock(input int ch, input logic [2:0] code);
    clk_src_type s;
    s.kind = SRC_INT;
    s.exp = UNLISTED_DIV_EXP[ch][code];
    s.pin = PIN_A;
    case (ch)
      0: begin
        if (code[2]) begin
          s.kind = SRC_EXT;
          s.pin = code[1:0];
        end else if (code == 3'h0) begin
          s.exp = EXP_DIV1;
        end else if (code == 3'h1) begin
          s.exp = EXP_DIV4;
        end
      end
      1: begin
        case (code)
          3'h0: s.exp = EXP_DIV1;
          3'h1: s.exp = EXP_DIV4;
          3'h2: s.exp = EXP_DIV16;
          3'h3: s.exp = EXP_DIV64;
          3'h4: s.kind = SRC_EXT;
          3'h5: begin
            s.kind = SRC_EXT;
            s.pin = PIN_B;
          end
          3'h6: s.exp = EXP_DIV256;
          default: s.kind = SRC_CASCADE;
        endcase
      end
      2: begin
        case (code)
          3'h0: s.exp = EXP_DIV1;
          3'h1: s.exp = EXP_DIV4;
          3'h4, 3'h5, 3'h6: begin
            s.kind = SRC_EXT;
            s.pin = code[1:0];
          end
          default: s.kind = SRC_INT;
        endcase
      end
      3: begin
        case (code)
          3'h0: s.exp = EXP_DIV1;
          3'h1: s.exp = EXP_DIV4;
          3'h3: s.exp = EXP_DIV64;
          3'h4: s.kind = SRC_EXT;
          3'h5: s.exp = EXP_DIV1024;
          3'h7: s.exp = EXP_DIV4096;
          default: s.kind = SRC_INT;
        endcase
      end
      4: begin
        case (code)
          3'h4: s.kind = SRC_EXT;
          3'h5: begin
            s.kind = SRC_EXT;
            s.pin = PIN_C;
          end
          3'h7: s.kind = SRC_CASCADE;
          default: s.kind = SRC_INT;
        endcase
      end
      default: begin
        case (code)
          3'h0: s.exp = EXP_DIV1;
          3'h4: s.kind = SRC_EXT;
          3'h5: begin
            s.kind = SRC_EXT;
            s.pin = PIN_C;
          end
          3'h7: begin
            s.kind = SRC_EXT;
            s.pin = PIN_D;
          end
          default: s.kind = SRC_INT;
        endcase
      end
    endcase
    return s;
  endfunction : decode_clock

  // register writes; no lock against running counters, software keeps to stopped channels
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_control <= {NUM_CH{CTRL_RESET}};
    end else if (reg_write_i && ctrl_hit(reg_addr_i)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_i == OFS_CTRL_BASE + ADDR_W'(i)) begin
          timer_control[i] <= is_narrow(i) ? (reg_wdata_i & CTRL_MASK_NARROW)
                                           : reg_wdata_i;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_operation_register <= SYNC_RESET;
      phase_enable <= PHASE_RESET;
      buffer_select <= BUFFER_RESET;
      counter_start <= START_RESET;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        OFS_SYNC: sync_operation_register <= reg_wdata_i[NUM_CH-1:0];
        OFS_PHASE: phase_enable <= reg_wdata_i[NUM_CH-1:0] & PHASE_CAPABLE;
        OFS_BUFFER: buffer_select <= reg_wdata_i[3:0];
        OFS_START: counter_start <= reg_wdata_i[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_read_i) begin
      reg_rdata_o <= '0;
    end else if (ctrl_hit(reg_addr_i)) begin
      reg_rdata_o <= timer_control[reg_addr_i - OFS_CTRL_BASE];
    end else begin
      case (reg_addr_i)
        OFS_SYNC: reg_rdata_o <= {2'h0, sync_operation_register};
        OFS_PHASE: reg_rdata_o <= {2'h0, phase_enable};
        OFS_BUFFER: reg_rdata_o <= {4'h0, buffer_select};
        OFS_START: reg_rdata_o <= {2'h0, counter_start};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // free running prescaler; bit k is the internal clock divided by 2^(k+1)
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prescaler <= '0;
      prescaler_prev <= '0;
    end else begin
      prescaler <= prescaler + PRE_W'(1);
      prescaler_prev <= prescaler;
    end
  end

  assign pre_rise = prescaler & ~prescaler_prev;
  assign pre_fall = ~prescaler & prescaler_prev;

  // pins are asynchronous: two flops, then a third for edge detection
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= ext_clock_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // count enables
  always_comb begin
    clk_src_type src;
    logic [1:0] edge_sel;
    logic [3:0] bit_idx;
    src = '0;
    edge_sel = '0;
    bit_idx = '0;
    count_tick = '0;
    count_down = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      src = decode_clock(i, timer_control[i][CLK_MSB:CLK_LSB]);
      edge_sel = timer_control[i][EDGE_MSB:EDGE_LSB];
      bit_idx = src.exp - 4'h1;
      case (src.kind)
        SRC_INT: begin
          if (src.exp == EXP_DIV1) begin
            count_tick[i] = 1'b1;
          end else if (edge_sel[1]) begin
            count_tick[i] = pre_rise[bit_idx] | pre_fall[bit_idx];
          end else begin
            count_tick[i] = edge_sel[0] ? pre_rise[bit_idx] : pre_fall[bit_idx];
          end
        end
        SRC_EXT: begin
          if (edge_sel[1]) begin
            count_tick[i] = pin_rise[src.pin] | pin_fall[src.pin];
          end else begin
            count_tick[i] = edge_sel[0] ? pin_fall[src.pin] : pin_rise[src.pin];
          end
        end
        SRC_CASCADE: begin
          count_tick[i] = (i < NUM_CH - 1) ? carry_o[(i + 1) % NUM_CH] : 1'b0;
        end
        default: count_tick[i] = 1'b0;
      endcase
      if (phase_enable[i]) begin
        count_tick[i] = phase_i.step[i];
        count_down[i] = phase_i.down[i];
      end
      count_tick[i] = count_tick[i] & counter_start[i];
    end
  end

  // clear sources
  always_comb begin
    logic [2:0] code;
    logic buf_c;
    logic buf_d;
    logic partner;
    code = '0;
    buf_c = 1'b0;
    buf_d = 1'b0;
    partner = 1'b0;
    own_clear = '0;
    next_clear = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      code = timer_control[i][CLR_MSB:CLR_LSB];
      if (is_narrow(i)) begin
        code[2] = 1'b0;
      end
      buf_c = (i == 0) ? buffer_select[BUF_C_CH0] : (i == 3) ? buffer_select[BUF_C_CH3] : 1'b0;
      buf_d = (i == 0) ? buffer_select[BUF_D_CH0] : (i == 3) ? buffer_select[BUF_D_CH3] : 1'b0;
      case (code)
        CLR_A: own_clear[i] = tgr_event_i.a[i];
        CLR_B: own_clear[i] = tgr_event_i.b[i];
        CLR_C: own_clear[i] = tgr_event_i.c[i] & ~buf_c;
        CLR_D: own_clear[i] = tgr_event_i.d[i] & ~buf_d;
        default: own_clear[i] = 1'b0;
      endcase
    end
    // only channels clearing from their own source drive the partners
    for (int i = 0; i < NUM_CH; i++) begin
      code = timer_control[i][CLR_MSB:CLR_LSB];
      partner = 1'b0;
      for (int j = 0; j < NUM_CH; j++) begin
        if (j != i) begin
          partner = partner | (own_clear[j] & sync_operation_register[j]);
        end
      end
      next_clear[i] = own_clear[i]
                    | ((code[1:0] == CLR_SYNC_LOW) && sync_operation_register[i]
                       && partner);
    end
  end

  // clear wins over a count in the same cycle
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_channel
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        channel_counter_o[g] <= CNT_ZERO;
        carry_o[g] <= 1'b0;
        counter_clear_o[g] <= 1'b0;
      end else begin
        counter_clear_o[g] <= next_clear[g];
        carry_o[g] <= count_tick[g] && !next_clear[g]
                    && (count_down[g] ? (channel_counter_o[g] == CNT_ZERO)
                                      : (channel_counter_o[g] == CNT_MAX));
        if (next_clear[g]) begin
          channel_counter_o[g] <= CNT_ZERO;
        end else if (count_tick[g]) begin
          channel_counter_o[g] <= count_down[g] ? channel_counter_o[g] - CNT_W'(1)
                                                : channel_counter_o[g] + CNT_W'(1);
        end
      end
    end
  end

endmodule : timer_count_clock_clear_select

/* timer_sel_assertions.sv */
// port-level checks for the timer clock and clear select block
// assumes one clock domain; shadows only the channel 0 control and buffer registers
`timescale 1ns/10ps
module timer_sel_assertions
  import timer_sel_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [REG_W-1:0] reg_rdata_o,
  input wire tgr_event_type tgr_event_i,
  input wire phase_type phase_i,
  input wire logic [NUM_PINS-1:0] ext_clock_pin_i,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] channel_counter_o,
  input wire logic [NUM_CH-1:0] counter_clear_o,
  input wire logic [NUM_CH-1:0] carry_o
);
  logic [REG_W-1:0] ctrl0;
  logic [3:0] bufr;

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl0 <= CTRL_RESET;
      bufr <= BUFFER_RESET;
    end else if (reg_write_i && reg_addr_i == OFS_CTRL_BASE) begin
      ctrl0 <= reg_wdata_i;
    end else if (reg_write_i && reg_addr_i == OFS_BUFFER) begin
      bufr <= reg_wdata_i[3:0];
    end
  end

  a_rdata_idle:
    assert property (!reg_read_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
  a_unmapped_zero:
    assert property (reg_read_i && reg_addr_i > 4'h9 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
  a_reserved_msb:
    assert property (reg_read_i && reg_addr_i inside {4'h1, 4'h2, 4'h4, 4'h5}
      |=> !reg_rdata_o[7]) else $error("reserved clear bit reads one");
  a_ctrl_readback:
    assert property (reg_read_i && reg_addr_i == OFS_CTRL_BASE
      |=> reg_rdata_o == $past(ctrl0)) else $error("control readback wrong");
  a_clear_zero:
    assert property (counter_clear_o[0] |-> channel_counter_o[0] == CNT_ZERO)
      else $error("cleared counter not zero");
  a_count_step:
    assert property ($changed(channel_counter_o[0]) |-> channel_counter_o[0] == CNT_ZERO
      || channel_counter_o[0] == $past(channel_counter_o[0]) + 16'h0001
      || channel_counter_o[0] == $past(channel_counter_o[0]) - 16'h0001)
      else $error("counter jumped");
  a_clear_on_a:
    assert property (ctrl0[7:5] == CLR_A && tgr_event_i.a[0] |=> counter_clear_o[0])
      else $error("clear on A missed");
  a_buffered_c:
    assert property (ctrl0[7:5] == CLR_C && bufr[BUF_C_CH0] |=> !counter_clear_o[0])
      else $error("buffered C cleared counter");
endmodule : timer_sel_assertions

bind timer_count_clock_clear_select timer_sel_assertions i_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .tgr_event_i(tgr_event_i), .phase_i(phase_i),
  .ext_clock_pin_i(ext_clock_pin_i), .channel_counter_o(channel_counter_o),
  .counter_clear_o(counter_clear_o), .carry_o(carry_o));

/* ext_clock_model.sv */
// external clock pin source: a burst of pulses on one selected pin
// pins rest low between bursts, so every burst ends where it began
`timescale 1ns/10ps
module ext_clock_model
  import timer_sel_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [1:0] pin_sel_i,
  input wire logic [3:0] pulses_i,
  output logic [NUM_PINS-1:0] ext_clock_pin_o,
  output logic busy_o
);
  logic [4:0] halves;
  logic [1:0] slow;

  // four cycles per half period, well above the two-flop synchroniser
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halves <= 5'h00;
      slow <= 2'h0;
      ext_clock_pin_o <= 4'h0;
    end else if (go_i) begin
      halves <= {pulses_i, 1'b0};
      slow <= 2'h0;
    end else if (halves != 5'h00) begin
      slow <= slow + 2'h1;
      if (slow == 2'h3) begin
        halves <= halves - 5'h01;
        ext_clock_pin_o[pin_sel_i] <= ~ext_clock_pin_o[pin_sel_i];
      end
    end
  end

  assign busy_o = halves != 5'h00;
endmodule : ext_clock_model

/* tb.sv */
// self-checking bench: register port, clock selection, edges and clear sources
// assumes the offsets and start register chosen in the package
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  import timer_sel_pkg::*;
  typedef struct {int ch; logic [7:0] ctl; int pin; int cyc; int ex;} cnt_case_type;
  typedef struct {int t; logic [7:0] c0, ct, sy, bf; int k; logic ex;} clr_case_type;
  logic core_clk_i, rst_b_i, reg_write_i, reg_read_i, go, busy;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [REG_W-1:0] reg_wdata_i, reg_rdata_o;
  tgr_event_type tgr_event_i;
  phase_type phase_i;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_CH-1:0][CNT_W-1:0] cnt;
  logic [NUM_CH-1:0] clr;
  logic [NUM_CH-1:0] cry;
  logic [1:0] psel;
  logic [CNT_W-1:0] c1;
  int errors, checked;
  // pin 4 means an internal source measured over cyc cycles
  cnt_case_type cc[] = '{'{0,8'h18,4,16,16}, '{0,8'h01,4,64,16}, '{0,8'h09,4,64,16},
    '{3,8'h11,4,64,32}, '{1,8'h02,4,64,4}, '{1,8'h03,4,128,2}, '{1,8'h06,4,512,2},
    '{3,8'h03,4,128,2}, '{3,8'h05,4,2048,2}, '{3,8'h07,4,8192,2}, '{2,8'h00,4,16,16},
    '{5,8'h00,4,16,16}, '{0,8'h04,0,0,3}, '{0,8'h0C,0,0,3}, '{0,8'h14,0,0,6},
    '{0,8'h05,1,0,3}, '{0,8'h06,2,0,3}, '{0,8'h07,3,0,3}, '{1,8'h05,1,0,3},
    '{2,8'h06,2,0,3}, '{3,8'h04,0,0,3}, '{4,8'h05,2,0,3}, '{5,8'h07,3,0,3}};
  clr_case_type kc[] = '{'{0,8'h20,8'h20,0,0,0,1}, '{0,8'h40,8'h40,0,0,1,1},
    '{0,8'hA0,8'hA0,0,0,2,1}, '{0,8'hC0,8'hC0,0,0,3,1}, '{0,8'h80,8'h80,0,0,0,0},
    '{3,0,8'hA0,0,4,2,0}, '{3,0,8'hC0,0,8,3,0}, '{3,0,8'hC0,0,0,3,1},
    '{1,0,8'h20,0,0,0,1}, '{1,0,8'h40,0,0,1,1}, '{1,8'h20,8'h60,3,0,0,1},
    '{1,8'h20,8'h60,1,0,0,0}, '{1,8'h20,8'h60,2,0,0,0}, '{3,8'h20,8'hE0,9,0,0,1}};

  timer_count_clock_clear_select i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .tgr_event_i(tgr_event_i),
    .phase_i(phase_i), .ext_clock_pin_i(pins), .channel_counter_o(cnt),
    .counter_clear_o(clr), .carry_o(cry));
  ext_clock_model i_pins (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .go_i(go),
    .pin_sel_i(psel), .pulses_i(4'h3), .ext_clock_pin_o(pins), .busy_o(busy));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 `CHK(reg_rdata_o, ex)
  endtask : rd

  // selections change only with every channel stopped
  task automatic setup(input int ch, input logic [7:0] ctl);
    wr(OFS_START, 8'h00);
    wr(4'(ch), ctl);
    wr(OFS_START, 8'h3F);
  endtask : setup

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial begin
    #400_000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {rst_b_i, reg_write_i, reg_read_i, go, psel, reg_addr_i, reg_wdata_i} = '0;
    tgr_event_i = '0;
    phase_i = '0;
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(OFS_SYNC, 8'h00);
    rd(4'hA, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(0, 8'hFF);
    rd(0, 8'hFF);
    for (int i = 1; i < 6; i++) begin
      wr(4'(i), 8'hFF);
      rd(4'(i), i == 3 ? 8'hFF : 8'h7F);
    end
    $display("register test done");
    foreach (cc[i]) begin
      setup(cc[i].ch, cc[i].ctl);
      repeat (8) @(posedge core_clk_i);
      #1 c1 = cnt[cc[i].ch];
      if (cc[i].pin < 4) begin
        @(posedge core_clk_i);
        go <= 1'b1;
        psel <= 2'(cc[i].pin);
        @(posedge core_clk_i);
        go <= 1'b0;
        #1 while (busy) @(posedge core_clk_i);
        repeat (8) @(posedge core_clk_i);
      end else begin
        repeat (cc[i].cyc) @(posedge core_clk_i);
      end
      #1 `CHK(cnt[cc[i].ch] - c1, 16'(cc[i].ex))
    end
    $display("clock select test done");
    foreach (kc[i]) begin
      wr(OFS_START, 8'h00);
      wr(0, kc[i].c0);
      wr(4'(kc[i].t), kc[i].ct);
      wr(OFS_SYNC, kc[i].sy);
      wr(OFS_BUFFER, kc[i].bf);
      wr(OFS_START, 8'h3F);
      repeat (4) @(posedge core_clk_i);
      tgr_event_i <= tgr_event_type'((24'h1 | (24'h1 << kc[i].t)) << (6 * (3 - kc[i].k)));
      @(posedge core_clk_i);
      tgr_event_i <= '0;
      #1 `CHK(clr[kc[i].t], kc[i].ex)
      if (kc[i].ex) `CHK(cnt[kc[i].t], CNT_ZERO)
    end
    $display("clear select test done");
    wr(OFS_PHASE, 8'h3F);
    rd(OFS_PHASE, 8'h36);
    setup(1, 8'h1A);
    #1 c1 = cnt[1];
    repeat (16) @(posedge core_clk_i);
    #1 `CHK(cnt[1], c1)
    phase_i <= phase_type'(12'h082);
    repeat (3) @(posedge core_clk_i);
    phase_i <= '0;
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(cnt[1] - c1, 16'hFFFD)
    $display("phase test done");
    // channel 2 zeroed, then one phase step down underflows it into channel 1
    wr(OFS_PHASE, 8'h04);
    setup(2, 8'h20);
    setup(1, 8'h07);
    tgr_event_i <= tgr_event_type'(24'h1 << 20);
    @(posedge core_clk_i);
    tgr_event_i <= '0;
    phase_i <= phase_type'(12'h104);
    #1 c1 = cnt[1];
    @(posedge core_clk_i);
    phase_i <= '0;
    #1 `CHK(cry[2], 1'b1)
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(cnt[1] - c1, 16'h0001)
    $display("cascade test done");
    print_verdict();
  end
endmodule : tb
